/* rpc_ctrl.sv */
// regulator preset control: preset registers, select pins and sequencer
`timescale 1ns/1ps
module rpc_ctrl
    import rpc_pkg::*;
#(
    parameter bit WIDE = 1'b0,
    parameter logic [7:0] PRESET0_DEF = PRESET0_RST,
    parameter logic [7:0] PRESET1_DEF = PRESET1_RST,
    parameter logic [7:0] PRESET2_DEF = PRESET2_RST,
    parameter logic [7:0] PRESET3_DEF = PRESET3_RST,
    parameter logic [RAMP_CNT_W-1:0] SOFT_STEP_CYCLES =
        RAMP_CNT_W'(SOFT_STEP_CYC)
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic en_pin_i,
    input wire logic preset_pick_bit0_i,
    input wire logic preset_pick_bit1_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [2:0] ramp_code_i,
    input wire logic discharge_when_off_i,
    output logic power_on_o,
    output logic regulating_o,
    output logic [SOFT_LVL_W-1:0] soft_level_o,
    output logic [VCODE_W-1:0] setpoint_o,
    output logic force_pwm_o,
    output logic discharge_o,
    output logic [1:0] active_preset_o
);

localparam logic [6:0] VMASK = WIDE ? VMASK_WIDE : VMASK_NARROW;
localparam logic [7:0] WMASK = {1'b1, VMASK};

// ----------------------------------------------------------------------
// pin synchronisation
// ----------------------------------------------------------------------
logic en_s;
logic [1:0] pick_s;

rpc_sync #(
    .WIDTH(3)
) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({en_pin_i, preset_pick_bit1_i, preset_pick_bit0_i}),
    .sync_o({en_s, pick_s})
);

// ----------------------------------------------------------------------
// preset registers
// ----------------------------------------------------------------------
logic [7:0] preset_reg [PRESET_NUM];
logic [7:0] preset_next [PRESET_NUM];
logic [7:0] rdata_reg, rdata_next;

always_comb begin
    for (int i = 0; i < PRESET_NUM; i++) begin
        preset_next[i] = preset_reg[i];
    end
    rdata_next = RDATA_RST;
    // access ignores the converter state
    if (reg_wr_i && rpc_addr_hit(reg_addr_i)) begin
        preset_next[reg_addr_i[1:0]] = reg_wdata_i & WMASK;
    end
    if (reg_rd_i && rpc_addr_hit(reg_addr_i)) begin
        rdata_next = preset_reg[reg_addr_i[1:0]];
    end
end

always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
        preset_reg[0] <= PRESET0_DEF & WMASK;
        preset_reg[1] <= PRESET1_DEF & WMASK;
        preset_reg[2] <= PRESET2_DEF & WMASK;
        preset_reg[3] <= PRESET3_DEF & WMASK;
        rdata_reg <= RDATA_RST;
    end else begin
        for (int i = 0; i < PRESET_NUM; i++) begin
            preset_reg[i] <= preset_next[i];
        end
        rdata_reg <= rdata_next;
    end
end

// ----------------------------------------------------------------------
// active preset decode
// ----------------------------------------------------------------------
logic [VCODE_W-1:0] target_code;
logic target_mode;

always_comb begin
    target_code = preset_reg[pick_s][VCODE_W-1:0] & VMASK;
    target_mode = preset_reg[pick_s][PRESET_OP_CHOICE_BIT];
end

// ----------------------------------------------------------------------
// enable, soft start and ramp sequencer
// ----------------------------------------------------------------------
rpc_state_e state_reg, state_next;
logic [VCODE_W-1:0] sp_reg, sp_next;
logic [SOFT_LVL_W-1:0] soft_reg, soft_next;
logic [RAMP_CNT_W-1:0] cnt_reg, cnt_next;
logic pwm_reg, pwm_next;
logic dis_reg, dis_next;
logic [RAMP_CNT_W-1:0] step_cycles;

always_comb begin
    step_cycles = rpc_ramp_cycles(ramp_code_i);
    state_next = state_reg;
    sp_next = sp_reg;
    soft_next = soft_reg;
    cnt_next = cnt_reg;
    pwm_next = target_mode;
    dis_next = !en_s && discharge_when_off_i;
    case (state_reg)
        ST_OFF: begin
            sp_next = '0;
            soft_next = '0;
            cnt_next = '0;
            if (en_s) begin
                state_next = ST_SOFT;
            end
        end
        ST_SOFT: begin
            if (cnt_reg >= SOFT_STEP_CYCLES - 10'h001) begin
                cnt_next = '0;
                if (soft_reg == SOFT_LAST) begin
                    state_next = ST_RAMP;
                end else begin
                    soft_next = soft_reg + 4'h1;
                end
            end else begin
                cnt_next = cnt_reg + 10'h001;
            end
        end
        ST_RAMP: begin
            if (sp_reg == target_code) begin
                state_next = ST_REG;
                cnt_next = '0;
            end else if (cnt_reg >= step_cycles - 10'h001) begin
                cnt_next = '0;
                if (sp_reg < target_code) begin
                    sp_next = sp_reg + 7'h01;
                end else begin
                    sp_next = sp_reg - 7'h01;
                end
            end else begin
                cnt_next = cnt_reg + 10'h001;
            end
        end
        ST_REG: begin
            // new target from pins or a write restarts the ramp
            if (sp_reg != target_code) begin
                state_next = ST_RAMP;
                cnt_next = '0;
            end
        end
        default: begin
            state_next = ST_OFF;
        end
    endcase
    if (!en_s) begin
        state_next = ST_OFF;
        sp_next = '0;
        soft_next = '0;
        cnt_next = '0;
    end
end

always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
        state_reg <= ST_OFF;
        sp_reg <= '0;
        soft_reg <= '0;
        cnt_reg <= '0;
        pwm_reg <= MODE_PSAVE;
        dis_reg <= 1'b0;
    end else begin
        state_reg <= state_next;
        sp_reg <= sp_next;
        soft_reg <= soft_next;
        cnt_reg <= cnt_next;
        pwm_reg <= pwm_next;
        dis_reg <= dis_next;
    end
end

// ----------------------------------------------------------------------
// outputs
// ----------------------------------------------------------------------
assign reg_rdata_o = rdata_reg;
assign power_on_o = state_reg != ST_OFF;
assign regulating_o = state_reg == ST_REG;
assign soft_level_o = soft_reg;
assign setpoint_o = sp_reg;
assign force_pwm_o = pwm_reg;
assign discharge_o = dis_reg;
assign active_preset_o = pick_s;

// ----------------------------------------------------------------------
// assertions
// ----------------------------------------------------------------------
default clocking cb @(posedge clk_i); endclocking
default disable iff (sys_rst_i);

sequence s_soft_done;
    state_reg == ST_SOFT && soft_reg == SOFT_LAST && en_s &&
        cnt_reg >= SOFT_STEP_CYCLES - 10'h001;
endsequence

sequence s_write_then_read;
    (reg_wr_i && rpc_addr_hit(reg_addr_i)) ##1
        (reg_rd_i && !reg_wr_i && reg_addr_i == $past(reg_addr_i));
endsequence

sequence s_active_write;
    (reg_wr_i && rpc_addr_hit(reg_addr_i) && reg_addr_i[1:0] == pick_s)
        ##1 $stable(pick_s);
endsequence

en_low_off_a: assert property (
    !en_s |=> state_reg == ST_OFF && sp_reg == 7'h00 && !power_on_o)
    else $error("converter not off after enable low");

en_start_a: assert property (
    state_reg == ST_OFF && en_s |=> state_reg == ST_SOFT ##0 power_on_o)
    else $error("enable high did not start soft start");

reg_live_a: assert property (
    s_write_then_read |=> reg_rdata_o == ($past(reg_wdata_i, 2) & WMASK))
    else $error("preset readback differs from written value");

disch_a: assert property (
    discharge_o |-> state_reg == ST_OFF && $past(discharge_when_off_i))
    else $error("discharge active while converter enabled");

disch_on_a: assert property (
    $past(!en_s && discharge_when_off_i) && !$past(sys_rst_i)
        |-> discharge_o)
    else $error("discharge missing while disabled");

soft_mono_a: assert property (
    state_reg == ST_SOFT && $past(state_reg) == ST_SOFT
        |-> soft_reg >= $past(soft_reg) && sp_reg == 7'h00)
    else $error("soft start not monotonic below minimum");

soft_done_a: assert property (
    s_soft_done |=> state_reg == ST_RAMP && sp_reg == 7'h00)
    else $error("soft start did not hand over at minimum");

ramp_step_a: assert property (
    state_reg == ST_RAMP && $past(state_reg) == ST_RAMP && $changed(sp_reg)
        |-> sp_reg == $past(sp_reg) + 7'h01 ||
            sp_reg == $past(sp_reg) - 7'h01)
    else $error("setpoint moved by more than one step");

ramp_rate_a: assert property (
    state_reg == ST_RAMP && $past(state_reg) == ST_RAMP && $changed(sp_reg)
        |-> $past(cnt_reg) >=
            rpc_ramp_cycles($past(ramp_code_i)) - 10'h001)
    else $error("setpoint stepped before the ramp interval");

reach_reg_a: assert property (
    state_reg == ST_RAMP && sp_reg == target_code && en_s
        |=> state_reg == ST_REG ##0 regulating_o)
    else $error("regulation not entered at target");

pick_move_a: assert property (
    state_reg == ST_REG && en_s && target_code != sp_reg
        |=> state_reg == ST_RAMP)
    else $error("new preset target not followed");

active_wr_a: assert property (
    s_active_write |-> target_code == ($past(reg_wdata_i[6:0]) & VMASK))
    else $error("active preset write not applied");

mode_follow_a: assert property (
    $stable(pick_s) && state_reg != ST_OFF ##1 $stable(pick_s)
        |-> force_pwm_o == $past(preset_reg[pick_s][PRESET_OP_CHOICE_BIT]))
    else $error("operating mode differs from selected preset");

rst_mode_a: assert property (
    $past(sys_rst_i) |-> !preset_reg[0][7] && !preset_reg[1][7] &&
        !preset_reg[2][7] && !preset_reg[3][7] && !discharge_o)
    else $error("presets not Power Save after reset");

narrow_a: assert property (
    !WIDE |-> !preset_reg[0][6] && !preset_reg[1][6] &&
        !preset_reg[2][6] && !preset_reg[3][6])
    else $error("narrow variant holds a seventh code bit");

ramp_after_soft_a: assert property (
    state_reg == ST_RAMP |-> soft_reg == SOFT_LAST)
    else $error("ramp began before soft start finished");

reg_hold_a: assert property (
    state_reg == ST_REG |-> sp_reg == $past(sp_reg))
    else $error("setpoint moved during regulation");

endmodule // rpc_ctrl

/* rpc_host.sv */
// behavioural host that programs the preset registers
`timescale 1ns/1ps
module rpc_host (
    input wire logic clk_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // ------------------------------------------------------------------
    // register access, any preset at any time, pins or bus or both
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge clk_i);
        #1;
        // released lines show no stale value
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_rd_o = 1'b1;
        reg_addr_o = a;
        @(posedge clk_i);
        #1;
        d = reg_rdata_i;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
    endtask

    // write, then read the same place in the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b1;
        reg_wdata_o = ~d;
        @(posedge clk_i);
        #1;
        q = reg_rdata_i;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
    endtask
endmodule // rpc_host

/* rpc_pkg.sv */
// constants, types and helpers of the regulator preset control
package rpc_pkg;

// ----------------------------------------------------------------------
// Overview of operation
// - enable high starts the power stage and regulation; low disables it
// - preset registers stay readable and writable whether enabled or not
// - discharge option is off after reset; when set, disable drains output
// - after enable, soft start rises monotonically to the minimum voltage
// - then setpoint ramps at the programmed rate to target; then regulate
// - select pins 00..11 pick presets 0..3 at addresses 0x00..0x03
// - a select pin change moves the target at once, no bus access needed
// - after reset all presets are Power Save with variant default voltage
// - presets hold voltage in 10 mV steps, narrow or wide range
// - each preset holds its own Power Save or forced PWM choice
// - one global ramp rate governs transitions for all presets
// - active and inactive presets may be rewritten while running
// - rewriting the active preset applies right after the write
// - bit 7 of each preset selects Power Save or forced PWM
// - voltage code is six bits narrow range, seven bits wide range
// ----------------------------------------------------------------------

localparam logic [7:0] ADDR_PRESET0 = 8'h00;
localparam logic [7:0] ADDR_PRESET1 = 8'h01;
localparam logic [7:0] ADDR_PRESET2 = 8'h02;
localparam logic [7:0] ADDR_PRESET3 = 8'h03;
localparam int PRESET_NUM = 4;
localparam int PRESET_OP_CHOICE_BIT = 7;
localparam int VCODE_W = 7;
localparam logic [6:0] VMASK_NARROW = 7'h3f;
localparam logic [6:0] VMASK_WIDE = 7'h7f;
localparam logic MODE_PSAVE = 1'b0;
localparam logic MODE_FPWM = 1'b1;
localparam logic [7:0] RDATA_RST = 8'h00;

// narrow-range defaults: 1.40, 1.00, 1.40, 1.10 V, all Power Save
localparam logic [7:0] PRESET0_RST = 8'h3f;
localparam logic [7:0] PRESET1_RST = 8'h17;
localparam logic [7:0] PRESET2_RST = 8'h3f;
localparam logic [7:0] PRESET3_RST = 8'h21;

// timing
localparam int CLK_PERIOD_PS = 40000;
localparam int RAMP_BASE_PS = 312500;
localparam int RAMP_CNT_W = 10;
localparam int SOFT_STEP_NS = 1000;
localparam int SOFT_STEP_CYC =
    (SOFT_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
localparam int SOFT_LVL_W = 4;
localparam logic [3:0] SOFT_LAST = 4'hf;

typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_SOFT = 2'b01,
    ST_RAMP = 2'b10,
    ST_REG = 2'b11
} rpc_state_e;

// cycles per 10 mV step for a ramp code, rounded down, at least one
function automatic logic [RAMP_CNT_W-1:0] rpc_ramp_cycles(
    input logic [2:0] code);
    int cyc;
    cyc = (RAMP_BASE_PS << code) / CLK_PERIOD_PS;
    if (cyc < 1) begin
        cyc = 1;
    end
    return cyc[RAMP_CNT_W-1:0];
endfunction

// true for an address that holds a preset
function automatic logic rpc_addr_hit(input logic [7:0] addr);
    return addr <= ADDR_PRESET3;
endfunction

endpackage

/* rpc_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module rpc_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
logic [WIDTH-1:0] s1_next, s2_next, s3_next, out_next;

always_comb begin
    s1_next = async_i;
    s2_next = s1_reg;
    s3_next = s2_reg;
    out_next = out_reg;
    // accept a level only once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
            out_next[i] = s3_reg[i];
        end
    end
end

always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
        s1_reg <= '0;
        s2_reg <= '0;
        s3_reg <= '0;
        out_reg <= '0;
    end else begin
        s1_reg <= s1_next;
        s2_reg <= s2_next;
        s3_reg <= s3_next;
        out_reg <= out_next;
    end
end

assign sync_o = out_reg;

endmodule // rpc_sync

/* testbench.sv */
// self-checking bench of the regulator preset control
`timescale 1ns/1ps
module testbench
    import rpc_pkg::*;
;
    localparam int SOFT_N = 2;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    // select and enable pins always at defined levels
    logic en_pin = 1'b0;
    logic pick0 = 1'b0;
    logic pick1 = 1'b0;
    logic disc = 1'b0;
    logic [2:0] ramp_code = 3'h0;
    logic reg_wr, reg_rd, power_on, regulating, force_pwm, discharge;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic [3:0] soft_level;
    logic [6:0] setpoint;
    logic [1:0] active_preset;
    logic [7:0] defs [4] = '{PRESET0_RST, PRESET1_RST, PRESET2_RST,
        PRESET3_RST};
    int errors = 0;
    int n_checks = 0;

    always #20 clk_i = ~clk_i;

    rpc_ctrl #(.SOFT_STEP_CYCLES(RAMP_CNT_W'(SOFT_N))) u_rpc_ctrl (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .en_pin_i(en_pin),
        .preset_pick_bit0_i(pick0), .preset_pick_bit1_i(pick1),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .ramp_code_i(ramp_code), .discharge_when_off_i(disc),
        .power_on_o(power_on), .regulating_o(regulating),
        .soft_level_o(soft_level), .setpoint_o(setpoint),
        .force_pwm_o(force_pwm), .discharge_o(discharge),
        .active_preset_o(active_preset));

    rpc_host u_rpc_host (
        .clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
        .reg_rdata_i(reg_rdata));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic set_pick(input logic [1:0] p);
        @(posedge clk_i);
        #1;
        pick0 = p[0];
        pick1 = p[1];
        cyc(6);
    endtask

    // wait for regulation; count cycles spent at setpoint lvl
    task automatic wait_reg(input logic up, input logic [6:0] lvl,
        output int ones);
        logic [3:0] last_s;
        logic [6:0] last_p;
        logic bad;
        int i;
        last_s = 4'h0;
        last_p = 7'h00;
        bad = 1'b0;
        ones = 0;
        for (i = 0; i < 3000 && regulating !== 1'b1; i++) begin
            cyc(1);
            if (up && (soft_level < last_s || setpoint < last_p)) begin
                bad = 1'b1;
            end
            if (setpoint === lvl) begin
                ones++;
            end
            last_s = soft_level;
            last_p = setpoint;
        end
        if (i >= 3000) begin
            errors++;
            $display("wrong value regulating expected 1 seen %b", regulating);
            give_verdict();
        end
        chk("monotonic rise", {7'h00, bad}, 8'h00);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        int ones;
        repeat (20) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        chk("power_on", {7'h00, power_on}, 8'h00);
        chk("discharge", {7'h00, discharge}, 8'h00);
        for (int p = 0; p < 4; p++) begin
            u_rpc_host.rd(8'(p), rd_val);
            chk("preset default", rd_val,
                {defs[p][7], defs[p][6:0] & VMASK_NARROW});
        end
        // programming while disabled, unmapped place included
        u_rpc_host.wr(8'h02, 8'hff);
        u_rpc_host.wr(8'h04, 8'h5a);
        u_rpc_host.wr_rd(8'h01, 8'h85, rd_val);
        chk("preset 1", rd_val, 8'h85);
        u_rpc_host.rd(8'h02, rd_val);
        chk("preset 2 narrow", rd_val, 8'hbf);
        u_rpc_host.rd(8'h04, rd_val);
        chk("unmapped", rd_val, 8'h00);
        for (int p = 0; p < 4; p++) begin
            set_pick(2'(p));
            chk("active preset", {6'h00, active_preset}, 8'(p));
            chk("mode", {7'h00, force_pwm}, {7'h00, p == 1 || p == 2});
        end
        // enable into preset 3 with discharge option set
        disc = 1'b1;
        en_pin = 1'b1;
        wait_reg(1'b1, 7'h01, ones);
        chk("setpoint start", {1'b0, setpoint}, 8'h21);
        chk("cycles per step", 8'(ones), 8'h07);
        chk("power_on", {7'h00, power_on}, 8'h01);
        // rewrite the active preset while running
        u_rpc_host.wr(8'h03, 8'ha3);
        cyc(2);
        wait_reg(1'b0, 7'h22, ones);
        chk("setpoint rewrite", {1'b0, setpoint}, 8'h23);
        chk("cycles per step up", 8'(ones), 8'h07);
        chk("mode rewrite", {7'h00, force_pwm}, 8'h01);
        // pins move the target down to preset 1, one ramp code slower
        ramp_code = 3'h1;
        set_pick(2'h1);
        wait_reg(1'b0, 7'h10, ones);
        chk("setpoint pins", {1'b0, setpoint}, 8'h05);
        chk("cycles per step down", 8'(ones), 8'h0f);
        u_rpc_host.rd(8'h03, rd_val);
        chk("preset 3 running", rd_val, 8'ha3);
        // disable with discharge
        en_pin = 1'b0;
        cyc(6);
        chk("power_on off", {7'h00, power_on}, 8'h00);
        chk("discharge on", {7'h00, discharge}, 8'h01);
        chk("setpoint off", {1'b0, setpoint}, 8'h00);
        give_verdict();
    end
endmodule // testbench
